/* File: rtl/sptsp_pkg.sv */
// package: constants and carrier types for the supervisor timing and serial slave block
package sptsp_pkg;
	// ****************************************
	// clock and times
	// ****************************************
	localparam int unsigned CLK_HZ         = 200_000_000;
	localparam int unsigned CLK_PERIOD_PS  = 5_000;
	localparam int unsigned WD_TIMEOUT_MS  = 50;
	localparam int unsigned AUTORESTART_MS = 50;
	localparam int unsigned UV_FILTER_NS   = 32_000;
	localparam int unsigned DIN_STATUS_NS  = 12_800;
	localparam int unsigned WAKEUP_NS      = 190_000;
	localparam int unsigned OVT_FILTER_NS  = 1_200;
	localparam int unsigned OVP_SET_NS     = 32_000;
	localparam int unsigned OVP_CLR_MS     = 10;
	localparam int unsigned FBF_SET_NS     = 1_600;
	localparam int unsigned FAIL_HZ        = 26_500;
	localparam int unsigned FALLBACK_HZ    = 200_000;
	// derived cycle counts; least times rounded up
	localparam int unsigned WD_CYC       = WD_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned AR_CYC       = AUTORESTART_MS * (CLK_HZ / 1000);
	localparam int unsigned UV_CYC       = (UV_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned DIN_CYC      = (DIN_STATUS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned WAKE_CYC     = (WAKEUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned OVT_CYC      = (OVT_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned OVP_SET_CYC  = (OVP_SET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned OVP_CLR_CYC  = OVP_CLR_MS * (CLK_HZ / 1000);
	localparam int unsigned FBF_CYC      = (FBF_SET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned FAIL_CYC     = CLK_HZ / FAIL_HZ;
	localparam int unsigned FB_HALF_CYC  = CLK_HZ / (2 * FALLBACK_HZ);
	localparam int unsigned CNT_W        = 24;
	localparam int unsigned SHIFT_W      = 8;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		SPTSP_STANDBY = 2'b00,
		SPTSP_WAKING  = 2'b01,
		SPTSP_ACTIVE  = 2'b11,
		SPTSP_LIMP    = 2'b10
	} sptsp_mode_type;

	typedef struct packed {
		logic battery_uv;
		logic over_temp;
		logic boost_ov;
		logic boost_fb;
	} sptsp_fault_type;

	typedef struct packed {
		logic sdo;
		logic sdo_oe_n;
		logic rx_valid;
		logic [SHIFT_W-1:0] rx_data;
	} sptsp_ser_type;
endpackage

/* File: rtl/sptsp_filter.sv */
// module: persistence filter with separate set and clear times
`timescale 1ns/10ps
`default_nettype none
module sptsp_filter
	import sptsp_pkg::*;
#(
	parameter int unsigned SET_CYC = 16,
	parameter int unsigned CLR_CYC = 1
) (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic cond,
	output logic      flag
);
	typedef struct packed {
		logic             flag;
		logic [CNT_W-1:0] cnt;
	} sptsp_flt_state_type;

	sptsp_flt_state_type state_ff;
	sptsp_flt_state_type nxt_state;

	always_comb begin
		nxt_state = state_ff;
		// count only while the input disagrees with the flag
		if (cond != state_ff.flag) begin
			if (state_ff.cnt + 1'b1 >= CNT_W'(cond ? SET_CYC : CLR_CYC)) begin
				nxt_state.flag = cond;
				nxt_state.cnt  = '0;
			end else begin
				nxt_state.cnt = state_ff.cnt + 1'b1;
			end
		end else begin
			nxt_state.cnt = '0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign flag = state_ff.flag;
endmodule
`default_nettype wire

/* File: rtl/sptsp_top.sv */
// module: supervisor timers, fault filters, reference clock monitor and serial slave
`timescale 1ns/10ps
`default_nettype none
module sptsp_top
	import sptsp_pkg::*;
#(
	parameter int unsigned WD_CYCLES   = WD_CYC,
	parameter int unsigned AR_CYCLES   = AR_CYC,
	parameter int unsigned WAKE_CYCLES = WAKE_CYC,
	parameter int unsigned OVP_CLR_CYCLES = OVP_CLR_CYC,
	parameter int unsigned FAIL_CYCLES = FAIL_CYC
) (
	input  wire logic            clk,
	input  wire logic            arst_n,
	input  wire logic            wd_trigger,
	input  wire logic            battery_supply_uv,
	input  wire logic            over_temp_raw,
	input  wire logic            boost_ov_raw,
	input  wire logic            boost_fb_raw,
	input  wire logic            direct_in,
	input  wire logic            dimming_reference_clock,
	input  wire logic            csn,
	input  wire logic            sck,
	input  wire logic            sdi,
	input  wire logic [SHIFT_W-1:0] tx_data,
	output sptsp_mode_type       mode,
	output logic                 restart_pulse,
	output logic                 direct_in_status,
	output sptsp_fault_type      faults,
	output logic                 ref_clk_failed,
	output logic                 dimming_clk,
	output sptsp_ser_type        ser
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [2:0]         csn_s;
		logic [2:0]         sck_s;
		logic [2:0]         sdi_s;
		logic [2:0]         din_s;
		logic [2:0]         ref_s;
		sptsp_mode_type     mode;
		logic [CNT_W-1:0]   tmr;
		logic [CNT_W-1:0]   din_cnt;
		logic               din_stat;
		logic [CNT_W-1:0]   ref_cnt;
		logic               ref_fail;
		logic [CNT_W-1:0]   fb_cnt;
		logic               fb_clk;
		logic               restart;
		logic [SHIFT_W-1:0] rx_sh;
		logic [SHIFT_W-1:0] tx_sh;
		logic [3:0]         bits;
		logic               rx_valid;
		logic [SHIFT_W-1:0] rx_data;
		logic               sdo;
		logic               oe_n;
	} sptsp_state_type;

	sptsp_state_type state_ff;
	sptsp_state_type nxt_state;

	// stable levels: second and third stage agree
	logic csn_lo, sck_rise, sck_fall, ref_rise, din_now, csn_rise, csn_fall, wake_req;
	assign csn_lo   = ~state_ff.csn_s[1] & ~state_ff.csn_s[2];
	assign csn_fall = ~state_ff.csn_s[1] & state_ff.csn_s[2];
	assign csn_rise = state_ff.csn_s[1] & ~state_ff.csn_s[2];
	assign sck_rise = state_ff.sck_s[1] & ~state_ff.sck_s[2];
	assign sck_fall = ~state_ff.sck_s[1] & state_ff.sck_s[2];
	assign ref_rise = state_ff.ref_s[1] & ~state_ff.ref_s[2];
	assign din_now  = state_ff.din_s[2];
	assign wake_req = csn_lo | (state_ff.din_s[1] & state_ff.din_s[2]);

	always_comb begin
		nxt_state = state_ff;
		nxt_state.csn_s = {state_ff.csn_s[1:0], csn};
		nxt_state.sck_s = {state_ff.sck_s[1:0], sck};
		nxt_state.sdi_s = {state_ff.sdi_s[1:0], sdi};
		nxt_state.din_s = {state_ff.din_s[1:0], direct_in};
		nxt_state.ref_s = {state_ff.ref_s[1:0], dimming_reference_clock};
		nxt_state.restart  = 1'b0;
		nxt_state.rx_valid = 1'b0;

		// ****************************************
		// mode sequencer
		// ****************************************
		unique case (state_ff.mode)
			SPTSP_STANDBY: begin
				nxt_state.tmr = '0;
				if (wake_req) begin
					nxt_state.mode = SPTSP_WAKING;
				end
			end
			SPTSP_WAKING: begin
				if (!wake_req) begin
					nxt_state.mode = SPTSP_STANDBY;
					nxt_state.tmr  = '0;
				end else if (state_ff.tmr + 1'b1 >= CNT_W'(WAKE_CYCLES)) begin
					nxt_state.mode = SPTSP_ACTIVE;
					nxt_state.tmr  = '0;
				end else begin
					nxt_state.tmr = state_ff.tmr + 1'b1;
				end
			end
			SPTSP_ACTIVE: begin
				if (wd_trigger) begin
					nxt_state.tmr = '0;
				end else if (state_ff.tmr + 1'b1 >= CNT_W'(WD_CYCLES)) begin
					nxt_state.mode = SPTSP_LIMP;
					nxt_state.tmr  = '0;
				end else begin
					nxt_state.tmr = state_ff.tmr + 1'b1;
				end
			end
			SPTSP_LIMP: begin
				// trigger leaves limp home; otherwise retry periodically
				if (wd_trigger) begin
					nxt_state.mode = SPTSP_ACTIVE;
					nxt_state.tmr  = '0;
				end else if (state_ff.tmr + 1'b1 >= CNT_W'(AR_CYCLES)) begin
					nxt_state.restart = 1'b1;
					nxt_state.tmr     = '0;
				end else begin
					nxt_state.tmr = state_ff.tmr + 1'b1;
				end
			end
		endcase

		// ****************************************
		// direct input status delay
		// ****************************************
		// a level still settling in the synchroniser restarts the count
		if ((din_now == state_ff.din_stat) || (state_ff.din_s[1] != state_ff.din_s[2])) begin
			nxt_state.din_cnt = '0;
		end else if (state_ff.din_cnt + 1'b1 >= CNT_W'(DIN_CYC)) begin
			nxt_state.din_stat = din_now;
			nxt_state.din_cnt  = '0;
		end else begin
			nxt_state.din_cnt = state_ff.din_cnt + 1'b1;
		end

		// ****************************************
		// reference clock monitor and fallback
		// ****************************************
		if (ref_rise) begin
			nxt_state.ref_cnt  = '0;
			nxt_state.ref_fail = 1'b0;
		end else if (state_ff.ref_cnt + 1'b1 >= CNT_W'(FAIL_CYCLES)) begin
			nxt_state.ref_fail = 1'b1;
		end else begin
			nxt_state.ref_cnt = state_ff.ref_cnt + 1'b1;
		end
		if (state_ff.fb_cnt + 1'b1 >= CNT_W'(FB_HALF_CYC)) begin
			nxt_state.fb_cnt = '0;
			nxt_state.fb_clk = ~state_ff.fb_clk;
		end else begin
			nxt_state.fb_cnt = state_ff.fb_cnt + 1'b1;
		end

		// ****************************************
		// serial slave (mode 0 style, msb first)
		// ****************************************
		// host period of 250 ns gives 50 cycles; filter delay is 15 ns
		if (csn_fall) begin
			nxt_state.oe_n  = 1'b0;
			nxt_state.sdo   = tx_data[SHIFT_W-1];
			nxt_state.tx_sh = tx_data;
			nxt_state.bits  = '0;
		end else if (csn_rise) begin
			nxt_state.oe_n = 1'b1;
		end else if (csn_lo) begin
			if (sck_rise) begin
				nxt_state.rx_sh = {state_ff.rx_sh[SHIFT_W-2:0], state_ff.sdi_s[2]};
				if (state_ff.bits == 4'(SHIFT_W - 1)) begin
					nxt_state.bits     = '0;
					nxt_state.rx_valid = 1'b1;
					nxt_state.rx_data  = {state_ff.rx_sh[SHIFT_W-2:0], state_ff.sdi_s[2]};
				end else begin
					nxt_state.bits = state_ff.bits + 1'b1;
				end
			end
			if (sck_fall) begin
				nxt_state.tx_sh = {state_ff.tx_sh[SHIFT_W-2:0], 1'b0};
				nxt_state.sdo   = state_ff.tx_sh[SHIFT_W-2];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= '{csn_s: 3'h7, oe_n: 1'b1, mode: SPTSP_STANDBY, default: '0};
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************
	// fault filters
	// ****************************************
	sptsp_filter #(.SET_CYC(UV_CYC), .CLR_CYC(1)) u_uv (
		.clk(clk), .arst_n(arst_n), .cond(battery_supply_uv), .flag(faults.battery_uv));
	sptsp_filter #(.SET_CYC(OVT_CYC), .CLR_CYC(1)) u_ovt (
		.clk(clk), .arst_n(arst_n), .cond(over_temp_raw), .flag(faults.over_temp));
	sptsp_filter #(.SET_CYC(OVP_SET_CYC), .CLR_CYC(OVP_CLR_CYCLES)) u_ovp (
		.clk(clk), .arst_n(arst_n), .cond(boost_ov_raw), .flag(faults.boost_ov));
	sptsp_filter #(.SET_CYC(FBF_CYC), .CLR_CYC(1)) u_fbf (
		.clk(clk), .arst_n(arst_n), .cond(boost_fb_raw), .flag(faults.boost_fb));

	assign mode             = state_ff.mode;
	assign restart_pulse    = state_ff.restart;
	assign direct_in_status = state_ff.din_stat;
	assign ref_clk_failed   = state_ff.ref_fail;
	// the host reference passes on through the three-stage synchroniser while it is healthy
	assign dimming_clk      = state_ff.ref_fail ? state_ff.fb_clk : state_ff.ref_s[2];
	assign ser.sdo          = state_ff.sdo;
	assign ser.sdo_oe_n     = state_ff.oe_n;
	assign ser.rx_valid     = state_ff.rx_valid;
	assign ser.rx_data      = state_ff.rx_data;

	// ****************************************
	// checks
	// ****************************************
	sequence s_csn_fall;
		csn_fall;
	endsequence
	sequence s_wd_expire;
		(state_ff.mode == SPTSP_ACTIVE && !wd_trigger) ##1 (state_ff.mode == SPTSP_LIMP);
	endsequence
	sequence s_wake_done;
		(state_ff.mode == SPTSP_WAKING) ##1 (state_ff.mode == SPTSP_ACTIVE);
	endsequence
	property p_oe_on;
		@(posedge clk) disable iff (!arst_n) s_csn_fall |=> !ser.sdo_oe_n;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("sdo not driven after csn fall");
	property p_oe_off;
		@(posedge clk) disable iff (!arst_n) csn_rise |=> ser.sdo_oe_n;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("sdo not released");
	property p_sdo_fall;
		@(posedge clk) disable iff (!arst_n)
			(csn_lo && !csn_fall && sck_fall) |=> ser.sdo == $past(state_ff.tx_sh[SHIFT_W-2]);
	endproperty
	a_sdo_fall: assert property (p_sdo_fall) else $error("sdo wrong after sck fall");
	property p_sdo_hold;
		@(posedge clk) disable iff (!arst_n)
			(csn_lo && !csn_fall && !sck_fall) |=> $stable(ser.sdo);
	endproperty
	a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved off sck fall");
	property p_rx;
		@(posedge clk) disable iff (!arst_n)
			ser.rx_valid |-> ser.rx_data[0] == $past(state_ff.sdi_s[2]);
	endproperty
	a_rx: assert property (p_rx) else $error("rx bit not from sck rise");
	property p_wd;
		@(posedge clk) disable iff (!arst_n)
			s_wd_expire |-> $past(state_ff.tmr) == CNT_W'(WD_CYCLES - 1);
	endproperty
	a_wd: assert property (p_wd) else $error("limp entered at wrong count");
	property p_ar;
		@(posedge clk) disable iff (!arst_n)
			restart_pulse |-> $past(state_ff.mode) == SPTSP_LIMP
				&& $past(state_ff.tmr) == CNT_W'(AR_CYCLES - 1);
	endproperty
	a_ar: assert property (p_ar) else $error("autorestart at wrong time");
	property p_wake;
		@(posedge clk) disable iff (!arst_n)
			s_wake_done |-> $past(state_ff.tmr) == CNT_W'(WAKE_CYCLES - 1);
	endproperty
	a_wake: assert property (p_wake) else $error("wake-up at wrong time");
	property p_din;
		@(posedge clk) disable iff (!arst_n)
			$changed(direct_in_status) |-> $past(state_ff.din_cnt) == CNT_W'(DIN_CYC - 1);
	endproperty
	a_din: assert property (p_din) else $error("din status timing wrong");
	property p_fail;
		@(posedge clk) disable iff (!arst_n)
			$rose(ref_clk_failed) |-> $past(state_ff.ref_cnt) == CNT_W'(FAIL_CYCLES - 1);
	endproperty
	a_fail: assert property (p_fail) else $error("reference fail at wrong time");
	property p_ref_back;
		@(posedge clk) disable iff (!arst_n) ref_rise |=> !ref_clk_failed;
	endproperty
	a_ref_back: assert property (p_ref_back) else $error("reference failure not cleared");
	property p_fb;
		@(posedge clk) disable iff (!arst_n)
			ref_clk_failed |-> dimming_clk == state_ff.fb_clk;
	endproperty
	a_fb: assert property (p_fb) else $error("fallback clock not selected");
	property p_fb_half;
		@(posedge clk) disable iff (!arst_n)
			$changed(state_ff.fb_clk) |-> $past(state_ff.fb_cnt) == CNT_W'(FB_HALF_CYC - 1);
	endproperty
	a_fb_half: assert property (p_fb_half) else $error("fallback half period wrong");
endmodule
`default_nettype wire

/* File: bench/sptsp_host_model.sv */
// host serial master model driving the serial slave port
`timescale 1ns/10ps
`default_nettype none
module sptsp_host_model (
	input  wire logic clk,
	input  wire logic sdo_line,
	input  wire logic sdo_oe_n,
	output var logic  csn,
	output var logic  sck,
	output var logic  sdi
);
	// ****************************************
	// byte transfer, msb first, mode 0
	// ****************************************
	// three phases of 130 ns give a 390 ns period, well above the floor
	localparam int HALF = 26;
	initial begin
		csn = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic oe_on,
		output logic oe_off);
		csn <= 1'b0;
		wt(20);
		#1;
		oe_on = sdo_oe_n;
		rx[7] = sdo_line;
		wt(HALF - 20);
		for (int i = 7; i >= 0; i--) begin
			sdi <= tx[i];
			wt(HALF);
			sck <= 1'b1;
			wt(HALF);
			sck <= 1'b0;
			wt(12);
			#1;
			// sampled 60 ns after the fall, not at the rise
			if (i > 0) rx[i-1] = sdo_line;
			wt(HALF - 12);
		end
		csn <= 1'b1;
		sdi <= ~sdi; // released line must not keep its last level
		wt(20);
		#1;
		oe_off = sdo_oe_n;
		wt(1200); // csn high time above 6 us
	endtask
endmodule
`default_nettype wire

/* File: bench/sptsp_tb_top.sv */
// testbench: timers, filters, reference monitor and serial port
`timescale 1ns/10ps
`default_nettype none
module sptsp_tb_top
	import sptsp_pkg::*;
;
	// ****************************************
	// signals
	// ****************************************
	localparam int unsigned WD_T = 200;
	localparam int unsigned AR_T = 300;
	localparam int unsigned WK_T = 100;
	localparam int unsigned OC_T = 500;
	logic               clk        = 1'b0;
	logic               arst_n     = 1'b0;
	logic               wd_trigger = 1'b0;
	logic               wd_en      = 1'b0;
	logic               ref_en     = 1'b0;
	logic               ref_clk    = 1'b0;
	logic               direct_in  = 1'b0;
	logic               sdo_last   = 1'b0;
	logic               dim_q      = 1'b0;
	logic [3:0]         raw        = 4'h0;
	logic [SHIFT_W-1:0] tx_data    = 8'h00;
	logic [7:0]         got_rx     = 8'h00;
	logic [7:0]         got;
	logic               on;
	logic               off;
	logic               csn;
	logic               sck;
	logic               sdi;
	logic               restart_pulse;
	logic               direct_in_status;
	logic               ref_clk_failed;
	logic               dimming_clk;
	wire logic          sdo_line;
	sptsp_mode_type     mode;
	sptsp_fault_type    faults;
	sptsp_ser_type      ser;
	int                 failures   = 0;
	int                 compares   = 0;
	int                 pulses     = 0;
	int                 dim_edges  = 0;
	int                 wd_cnt     = 0;
	int                 ref_cnt    = 0;
	int                 e0;
	int unsigned        set_t [4]  = '{UV_CYC, OVT_CYC, OVP_SET_CYC, FBF_CYC};
	logic [7:0]         tx_tab [2] = '{8'hA5, 8'h3C};
	logic [7:0]         rx_tab [2] = '{8'h5A, 8'hC3};

	always #2.5 clk = ~clk;
	assign sdo_line = ser.sdo_oe_n ? ~sdo_last : ser.sdo;

	sptsp_top #(.WD_CYCLES(WD_T), .AR_CYCLES(AR_T), .WAKE_CYCLES(WK_T),
		.OVP_CLR_CYCLES(OC_T), .FAIL_CYCLES(FAIL_CYC)) dut (
		.clk(clk), .arst_n(arst_n), .wd_trigger(wd_trigger),
		.battery_supply_uv(raw[3]), .over_temp_raw(raw[2]), .boost_ov_raw(raw[1]),
		.boost_fb_raw(raw[0]), .direct_in(direct_in), .dimming_reference_clock(ref_clk),
		.csn(csn), .sck(sck), .sdi(sdi), .tx_data(tx_data), .mode(mode),
		.restart_pulse(restart_pulse), .direct_in_status(direct_in_status),
		.faults(faults), .ref_clk_failed(ref_clk_failed), .dimming_clk(dimming_clk),
		.ser(ser));
	sptsp_host_model host (.clk(clk), .sdo_line(sdo_line), .sdo_oe_n(ser.sdo_oe_n),
		.csn(csn), .sck(sck), .sdi(sdi));

	// ****************************************
	// stimulus helpers and monitors
	// ****************************************
	always @(posedge clk) begin
		if (!ser.sdo_oe_n) sdo_last <= ser.sdo;
		if (ser.rx_valid) got_rx <= ser.rx_data;
		if (restart_pulse) pulses <= pulses + 1;
		dim_q <= dimming_clk;
		if (dimming_clk && !dim_q) dim_edges <= dim_edges + 1;
		wd_cnt <= wd_en ? (wd_cnt + 1) % 100 : 0;
		wd_trigger <= wd_en && wd_cnt == 0;
		ref_cnt <= ref_en ? (ref_cnt + 1) % 250 : 0;
		if (ref_en && ref_cnt == 249) ref_clk <= ~ref_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// settle past the edge before looking
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		#1;
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#(80000 * 5);
		failures++;
		close_out();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		tick(3);
		arst_n <= 1'b1;
		tick(1);
		check(mode, SPTSP_STANDBY);
		check(ser.sdo_oe_n, 1'b1);
		tick(1);
		direct_in <= 1'b1;
		wd_en <= 1'b1;
		tick(WK_T - 10);
		check(mode === SPTSP_ACTIVE, 1'b0);
		tick(20);
		check(mode, SPTSP_ACTIVE);
		tick(DIN_CYC - 140);
		check(direct_in_status, 1'b0);
		tick(40);
		check(direct_in_status, 1'b1);
		for (int i = 0; i < 4; i++) begin
			tick(1);
			raw[3-i] <= 1'b1;
			tick(set_t[i] - 3);
			check(faults[3-i], 1'b0);
			tick(8);
			check(faults[3-i], 1'b1);
			tick(1);
			raw[3-i] <= 1'b0;
			tick(8);
			check(faults[3-i], i == 2);
			tick(OC_T);
			check(faults[3-i], 1'b0);
		end
		tick(1);
		ref_en <= 1'b1;
		tick(1000);
		e0 = dim_edges;
		tick(2000);
		check(dim_edges - e0, 32'h4);
		check(ref_clk_failed, 1'b0);
		tick(1);
		ref_en <= 1'b0;
		tick(FAIL_CYC - 600);
		check(ref_clk_failed, 1'b0);
		tick(650);
		check(ref_clk_failed, 1'b1);
		e0 = dim_edges;
		tick(8 * FB_HALF_CYC);
		check(dim_edges - e0, 32'h4);
		tick(1);
		ref_en <= 1'b1;
		tick(520);
		check(ref_clk_failed, 1'b0);
		for (int i = 0; i < 2; i++) begin
			tick(1);
			tx_data <= tx_tab[i];
			tick(1);
			host.xfer(rx_tab[i], got, on, off);
			check(got, tx_tab[i]);
			check(got_rx, rx_tab[i]);
			check({on, off}, 2'h1);
		end
		tick(1);
		wd_en <= 1'b0;
		tick(WD_T + 120);
		check(mode, SPTSP_LIMP);
		tick(1);
		wd_en <= 1'b1;
		tick(1);
		wd_en <= 1'b0;
		tick(10);
		check(mode, SPTSP_ACTIVE);
		tick(WD_T - 20);
		check(mode, SPTSP_ACTIVE);
		tick(20);
		check(mode, SPTSP_LIMP);
		e0 = pulses;
		tick(2 * AR_T + 20);
		check(pulses - e0, 32'h2);
		// second reset in mid-run, then wake by chip select alone
		tick(1);
		direct_in <= 1'b0;
		wd_en     <= 1'b1;
		arst_n    <= 1'b0;
		tick(3);
		arst_n <= 1'b1;
		tick(1);
		check(mode, SPTSP_STANDBY);
		check(direct_in_status, 1'b0);
		tick(1);
		host.xfer(8'h96, got, on, off);
		check(mode, SPTSP_ACTIVE);
		check(got, tx_tab[1]);
		check(got_rx, 8'h96);
		close_out();
	end
endmodule
`default_nettype wire
